// ### core/ascr_defines.vh
// constants for the acceleration sensor status and configuration bank
`ifndef ASCR_DEFINES_VH
`define ASCR_DEFINES_VH

// register indexes; byte address is four times the index
`define ASCR_IDX_INT_STATUS 8'h1d
`define ASCR_IDX_TEMP       8'h22
`define ASCR_IDX_FILL_LOW   8'h24
`define ASCR_IDX_FILL_HIGH  8'h25
`define ASCR_IDX_DATA_PORT  8'h26
`define ASCR_IDX_HEALTH     8'h2a
`define ASCR_IDX_SAMPLING   8'h40
`define ASCR_IDX_WATERMARK  8'h46
`define ASCR_IDX_FEATURE    8'h4a
`define ASCR_IDX_MSB        9
`define ASCR_IDX_LSB        2

// reset values
`define ASCR_RST_BYTE       8'h00
`define ASCR_RST_SAMPLING   8'ha8
`define ASCR_RST_WATERMARK  8'h02
`define ASCR_RST_FEATURE    8'h24

// interrupt status bits
`define ASCR_ST_ACC_DRDY    7
`define ASCR_ST_AUX_DRDY    5
`define ASCR_ST_WATERMARK   1
`define ASCR_ST_FULL        0

// health report layout
`define ASCR_HL_RATE_FAULT  6
`define ASCR_HL_MAP_FAULT   5
`define ASCR_HL_CODE_MSB    4
`define ASCR_HL_RSVD        7

// sampling setup layout
`define ASCR_SS_FILT        7
`define ASCR_SS_BW_MSB      6
`define ASCR_SS_BW_LSB      4
`define ASCR_SS_RATE_MSB    3

// rate and bandwidth codes
`define ASCR_RATE_MIN       4'h1
`define ASCR_RATE_MAX       4'hc
`define ASCR_RATE_50HZ      4'h7
`define ASCR_BW_OSR4        3'h0
`define ASCR_BW_OSR2        3'h1
`define ASCR_BW_NORMAL      3'h2
`define ASCR_OSR_X4         2'h0
`define ASCR_OSR_X2         2'h1
`define ASCR_OSR_NORM       2'h2
`define ASCR_OSR_RESERVED   2'h3

// feature register layout
`define ASCR_FT_NEED_50HZ   6
`define ASCR_FT_MAP_MSB     5
`define ASCR_FT_MAP_Z_LSB   4
`define ASCR_FT_MAP_Y_MSB   3
`define ASCR_FT_MAP_Y_LSB   2
`define ASCR_FT_MAP_X_MSB   1

// buffer shape and counter width
`define ASCR_BUF_WIDTH      8
`define ASCR_BUF_DEPTH      4
`define ASCR_BUF_AW         2
`define ASCR_BUF_CW         3
`define ASCR_FILL_W         14
`define ASCR_FILL_PAD       11
`define ASCR_FILL_HI_LSB    8

`endif

// ### core/ascr_regs.v
// status and configuration register bank of an acceleration sensor
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "ascr_defines.vh"

module ascr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2,
    parameter CW    = 3
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o,
    output wire [CW-1:0]    count_o
);
    localparam [CW-1:0] FULL_CNT = DEPTH;
    localparam [CW-1:0] ONE_CNT  = 1;
    localparam [AW-1:0] ONE_PTR  = 1;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [CW-1:0]    count;
    reg [CW-1:0]    next_count;
    reg             in_ready;
    reg             out_valid;

    wire push = in_valid_i & in_ready;
    wire pop  = out_ready_i & out_valid;

    always @* begin
        next_count = count;
        if (push & ~pop) begin
            next_count = count + ONE_CNT;
        end else if (pop & ~push) begin
            next_count = count - ONE_CNT;
        end
    end

    // pointers wrap naturally; depth must stay a power of two
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {CW{1'b0}};
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + ONE_PTR;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + ONE_PTR;
            end
            count     <= next_count;
            in_ready  <= (next_count != FULL_CNT);
            out_valid <= (next_count != {CW{1'b0}});
        end
    end

    // data array carries no reset; empty reads are masked by the user
    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    assign in_ready_o  = in_ready;
    assign out_valid_o = out_valid;
    assign out_data_o  = mem[rd_ptr];
    assign count_o     = count;
endmodule

// Contract
// RQ1: reading the interrupt status register clears its flags, and it resets to zero.
// RQ2: status bit 7 is accel data ready, bit 5 aux data ready, bit 1 watermark, bit 0 full.
// RQ3: die temperature reads as a signed byte, one kelvin per step, zero meaning 23 C.
// RQ4: the fill level is a 14-bit byte count split over a low and a high register.
// RQ5: the data port returns one buffered byte per read, is read-only and resets to zero.
// RQ6: the health report carries the internal status code in bits 4..0.
// RQ7: health bit 5 flags two of X, Y, Z mapped onto the same physical axis.
// RQ8: health bit 6 flags 50 Hz features enabled with a slower configured rate.
// RQ9: the sampling setup byte resets to 0xa8 with filter, bandwidth and rate fields.
// RQ10: rate codes 0x01 to 0x0c are valid, 25/32 Hz doubling per step, others reserved.
// RQ11: the host picks a rate code supported by the chosen power mode.
// RQ12: filter bit 0 selects averaging, 1 selects the continuous filter.
// RQ13: continuous filter uses bandwidth 0 as osr4, 1 as osr2, 2 normal, rest reserved.
// RQ14: averaging uses two to the power of the bandwidth setting samples.
// RQ15: each data port read removes the byte and lowers the fill count by one.
// RQ16: writes to read-only registers are ignored and change nothing.
module ascr_regs (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    input  wire [3:0]  pstrb_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    input  wire        acc_drdy_i,
    input  wire        aux_drdy_i,
    input  wire [7:0]  temperature_i,
    input  wire [4:0]  init_state_i,
    input  wire        sample_valid_i,
    input  wire [7:0]  sample_data_i,
    output wire        sample_ready_o,
    output wire [3:0]  rate_code_o,
    output wire        rate_valid_o,
    output wire        filt_cont_o,
    output wire [1:0]  osr_mode_o,
    output wire [2:0]  avg_log2_o,
    output wire        bw_reserved_o,
    output wire [5:0]  axis_map_o
);
    reg        rst_sync_a;
    reg        rst_sync_b;
    wire       rst_n = rst_sync_b;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_a <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_sync_a <= 1'b1;
            rst_sync_b <= rst_sync_a;
        end
    end

    // buffer in the sample path; its ready stalls the source
    wire                     buf_out_valid;
    wire [`ASCR_BUF_WIDTH-1:0] buf_out_data;
    wire [`ASCR_BUF_CW-1:0]  buf_count;
    wire                     buf_in_ready;
    reg                      buf_pop;

    ascr_fifo #(
        .WIDTH (`ASCR_BUF_WIDTH),
        .DEPTH (`ASCR_BUF_DEPTH),
        .AW    (`ASCR_BUF_AW),
        .CW    (`ASCR_BUF_CW)
    ) u_buf (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (sample_data_i),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_pop),
        .out_data_o  (buf_out_data),
        .count_o     (buf_count)
    );

    reg [7:0]              interrupt_status_b;
    reg [7:0]              die_temperature;
    reg [`ASCR_FILL_W-1:0] buffer_fill;
    reg [7:0]              health_report;
    reg [7:0]              sampling_setup;
    reg [7:0]              buffer_watermark;
    reg [7:0]              feature_setup;

    reg [7:0]  rdata;
    reg        ready;
    reg        slverr;
    reg        pop_pend;
    reg        wtm_prev;
    reg        full_prev;

    reg [3:0]  rate_code;
    reg        rate_valid;
    reg        filt_cont;
    reg [1:0]  osr_mode;
    reg [2:0]  avg_log2;
    reg        bw_reserved;

    wire [7:0] idx     = paddr_i[`ASCR_IDX_MSB:`ASCR_IDX_LSB];
    // misaligned or out-of-page addresses get an error response
    wire       in_page = (paddr_i[11:`ASCR_IDX_MSB+1] == 2'b00) &&
                         (paddr_i[`ASCR_IDX_LSB-1:0] == 2'b00);
    wire       access  = psel_i & penable_i;
    wire       stage   = access & ~ready;
    wire       done    = access & ready;

    reg [7:0]  next_rdata;
    reg        next_hit;

    always @* begin
        next_rdata = `ASCR_RST_BYTE;
        next_hit   = in_page;
        case (idx)
            `ASCR_IDX_INT_STATUS: next_rdata = interrupt_status_b;
            `ASCR_IDX_TEMP:       next_rdata = die_temperature;      // see RQ3
            `ASCR_IDX_FILL_LOW:   next_rdata = buffer_fill[`ASCR_FILL_HI_LSB-1:0]; // see RQ4
            `ASCR_IDX_FILL_HIGH: begin
                next_rdata = {2'b00, buffer_fill[`ASCR_FILL_W-1:`ASCR_FILL_HI_LSB]}; // see RQ4
            end
            `ASCR_IDX_DATA_PORT: begin
                // empty buffer reads as zero, see RQ5
                next_rdata = buf_out_valid ? buf_out_data : `ASCR_RST_BYTE;
            end
            `ASCR_IDX_HEALTH:     next_rdata = health_report;
            `ASCR_IDX_SAMPLING:   next_rdata = sampling_setup;
            `ASCR_IDX_WATERMARK:  next_rdata = buffer_watermark;
            `ASCR_IDX_FEATURE:    next_rdata = {1'b0, feature_setup[`ASCR_FT_NEED_50HZ:0]};
            default: begin
                next_hit = 1'b0;
            end
        endcase
        if (!in_page) begin
            next_rdata = `ASCR_RST_BYTE;
        end
    end

    // one wait state: data latched in the first access cycle, effects at completion
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata    <= `ASCR_RST_BYTE;
            ready    <= 1'b0;
            slverr   <= 1'b0;
            pop_pend <= 1'b0;
        end else if (stage) begin
            rdata    <= pwrite_i ? `ASCR_RST_BYTE : next_rdata;
            ready    <= 1'b1;
            slverr   <= ~next_hit;
            // pop only a byte that was actually returned, see RQ15
            pop_pend <= ~pwrite_i & next_hit & buf_out_valid &
                        (idx == `ASCR_IDX_DATA_PORT);
        end else begin
            ready    <= 1'b0;
            slverr   <= 1'b0;
            pop_pend <= 1'b0;
        end
    end

    always @* begin
        buf_pop = done & pop_pend; // see RQ15
    end

    wire wr_done = done & pwrite_i & ~slverr & pstrb_i[0];
    wire rd_done = done & ~pwrite_i & ~slverr;

    // only writable registers decode writes; the rest ignore them, see RQ16
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sampling_setup   <= `ASCR_RST_SAMPLING; // see RQ9
            buffer_watermark <= `ASCR_RST_WATERMARK;
            feature_setup    <= `ASCR_RST_FEATURE;
        end else if (wr_done) begin
            case (idx)
                `ASCR_IDX_SAMPLING:  sampling_setup   <= pwdata_i[7:0]; // see RQ9
                `ASCR_IDX_WATERMARK: buffer_watermark <= pwdata_i[7:0];
                `ASCR_IDX_FEATURE:   feature_setup    <= {1'b0, pwdata_i[`ASCR_FT_NEED_50HZ:0]};
                default: begin
                    sampling_setup <= sampling_setup; // see RQ16
                end
            endcase
        end
    end

    // watermark and full are flagged on entry, not while they persist
    wire wtm_now  = (buffer_watermark != `ASCR_RST_BYTE) &&
                    (buffer_fill[`ASCR_FILL_HI_LSB-1:0] >= buffer_watermark);
    wire full_now = ~buf_in_ready;

    reg [7:0] status_set;

    always @* begin
        status_set = `ASCR_RST_BYTE;
        status_set[`ASCR_ST_ACC_DRDY]  = acc_drdy_i;          // see RQ2
        status_set[`ASCR_ST_AUX_DRDY]  = aux_drdy_i;          // see RQ2
        status_set[`ASCR_ST_WATERMARK] = wtm_now & ~wtm_prev; // see RQ2
        status_set[`ASCR_ST_FULL]      = full_now & ~full_prev; // see RQ2
    end

    // clear only what the read returned, so a late event survives the clear
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_status_b <= `ASCR_RST_BYTE; // see RQ1
            wtm_prev           <= 1'b0;
            full_prev          <= 1'b0;
        end else begin
            wtm_prev  <= wtm_now;
            full_prev <= full_now;
            if (rd_done && (idx == `ASCR_IDX_INT_STATUS)) begin
                interrupt_status_b <= (interrupt_status_b & ~rdata) | status_set; // see RQ1
            end else begin
                interrupt_status_b <= interrupt_status_b | status_set;
            end
        end
    end

    // axis map: x in bits 1..0, y in 3..2, z in 5..4
    wire [1:0] map_x = feature_setup[`ASCR_FT_MAP_X_MSB:0];
    wire [1:0] map_y = feature_setup[`ASCR_FT_MAP_Y_MSB:`ASCR_FT_MAP_Y_LSB];
    wire [1:0] map_z = feature_setup[`ASCR_FT_MAP_MSB:`ASCR_FT_MAP_Z_LSB];
    wire       map_fault  = (map_x == map_y) || (map_x == map_z) || (map_y == map_z);
    wire [3:0] cfg_rate   = sampling_setup[`ASCR_SS_RATE_MSB:0];
    // codes below 50 Hz starve features that need 50 Hz data
    wire       rate_fault = feature_setup[`ASCR_FT_NEED_50HZ] &&
                            (cfg_rate < `ASCR_RATE_50HZ);

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            die_temperature <= `ASCR_RST_BYTE;
            buffer_fill     <= {`ASCR_FILL_W{1'b0}};
            health_report   <= `ASCR_RST_BYTE;
        end else begin
            die_temperature <= temperature_i; // see RQ3
            // fill trails the buffer count by one cycle
            buffer_fill     <= {{`ASCR_FILL_PAD{1'b0}}, buf_count}; // see RQ4
            health_report[`ASCR_HL_RSVD]       <= 1'b0;
            health_report[`ASCR_HL_RATE_FAULT] <= rate_fault; // see RQ8
            health_report[`ASCR_HL_MAP_FAULT]  <= map_fault;  // see RQ7
            health_report[`ASCR_HL_CODE_MSB:0] <= init_state_i; // see RQ6
        end
    end

    // decoded sampling configuration for the acquisition path
    wire [2:0] cfg_bw   = sampling_setup[`ASCR_SS_BW_MSB:`ASCR_SS_BW_LSB];
    wire       cfg_filt = sampling_setup[`ASCR_SS_FILT];

    reg [1:0] next_osr;

    always @* begin
        case (cfg_bw)
            `ASCR_BW_OSR4:   next_osr = `ASCR_OSR_X4;   // see RQ13
            `ASCR_BW_OSR2:   next_osr = `ASCR_OSR_X2;   // see RQ13
            `ASCR_BW_NORMAL: next_osr = `ASCR_OSR_NORM; // see RQ13
            default: begin
                next_osr = `ASCR_OSR_RESERVED;
            end
        endcase
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rate_code   <= 4'h0;
            rate_valid  <= 1'b0;
            filt_cont   <= 1'b0;
            osr_mode    <= 2'h0;
            avg_log2    <= 3'h0;
            bw_reserved <= 1'b0;
        end else begin
            rate_code   <= cfg_rate;
            // reserved rate codes are flagged, not remapped, see RQ10
            rate_valid  <= (cfg_rate >= `ASCR_RATE_MIN) && (cfg_rate <= `ASCR_RATE_MAX);
            filt_cont   <= cfg_filt; // see RQ12
            osr_mode    <= cfg_filt ? next_osr : 2'h0;
            avg_log2    <= cfg_filt ? 3'h0 : cfg_bw; // see RQ14
            bw_reserved <= cfg_filt && (next_osr == `ASCR_OSR_RESERVED);
        end
    end

    assign prdata_o       = {24'h000000, rdata};
    assign pready_o       = ready;
    assign pslverr_o      = slverr;
    assign sample_ready_o = buf_in_ready;
    assign rate_code_o    = rate_code;
    assign rate_valid_o   = rate_valid;
    assign filt_cont_o    = filt_cont;
    assign osr_mode_o     = osr_mode;
    assign avg_log2_o     = avg_log2;
    assign bw_reserved_o  = bw_reserved;
    assign axis_map_o     = feature_setup[`ASCR_FT_MAP_MSB:0];
endmodule

// ### dv/ascr_host.sv
// host model that drives the register bus
`timescale 1ns/1ps
module ascr_host (
    input  wire logic        clk_i,
    input  wire logic        pready_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [11:0]      paddr_o,
    output logic [31:0]      pwdata_o,
    output logic [3:0]       pstrb_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h0;
        pwdata_o = 32'h0;
        pstrb_o = 4'h0;
    end

    // the request stands until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        pstrb_o <= s;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule

// ### dv/ascr_regs_checker.sv
// assertions on the ports of the register bank
`timescale 1ns/1ps
module ascr_regs_checker (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        sample_ready_o,
    input wire logic [3:0]  rate_code_o,
    input wire logic        rate_valid_o,
    input wire logic        filt_cont_o,
    input wire logic [1:0]  osr_mode_o,
    input wire logic [2:0]  avg_log2_o,
    input wire logic        bw_reserved_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire acc1 = psel_i && penable_i && !pready_o;
    wire fin  = psel_i && penable_i && pready_o;

    property p_one_wait; acc1 |=> pready_o; endproperty
    a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
    property p_pulse; pready_o |=> !pready_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_bad_addr;
        acc1 && (paddr_i[1:0] != 2'h0 || paddr_i[11:10] != 2'h0)
            |=> pslverr_o && (pwrite_i || prdata_o == 32'h0);
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped access not refused");
    property p_err_ready; pslverr_o |-> pready_o; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_upper; pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits not zero");
    property p_rate_ok; rate_valid_o == (rate_code_o >= 4'h1 && rate_code_o <= 4'hc); endproperty
    a_rate_ok: assert property (p_rate_ok) else $error("rate valid flag wrong");
    property p_split;
        filt_cont_o ? avg_log2_o == 3'h0 : (osr_mode_o == 2'h0 && !bw_reserved_o);
    endproperty
    a_split: assert property (p_split) else $error("filter style outputs mixed");
    property p_res; bw_reserved_o == (filt_cont_o && osr_mode_o == 2'h3); endproperty
    a_res: assert property (p_res) else $error("reserved bandwidth flag wrong");
    property p_cfg;
        fin && pwrite_i && pstrb_i[0] && paddr_i == 12'h100 |-> ##2
            rate_code_o == $past(pwdata_i[3:0], 2) && filt_cont_o == $past(pwdata_i[7], 2)
            && ($past(pwdata_i[7], 2) || avg_log2_o == $past(pwdata_i[6:4], 2));
    endproperty
    a_cfg: assert property (p_cfg) else $error("setup write not decoded");

    c_err: cover property (pslverr_o);
    c_full: cover property (!sample_ready_o);
    c_res: cover property (bw_reserved_o);
endmodule

bind ascr_regs ascr_regs_checker chk (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .sample_ready_o, .rate_code_o,
    .rate_valid_o, .filt_cont_o, .osr_mode_o, .avg_log2_o, .bw_reserved_o);

// ### dv/accel_status_config_regs_bench.sv
// self-checking bench for the sensor status and configuration bank
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module accel_status_config_regs_bench;
    logic        clk_i = 0, nrst_i = 0, acc_drdy_i = 0, aux_drdy_i = 0, sample_valid_i = 0;
    logic [7:0]  temperature_i = 0, sample_data_i = 0, b;
    logic [4:0]  init_state_i = 0;
    wire         psel_i, penable_i, pwrite_i, pready_o, pslverr_o, sample_ready_o;
    wire  [11:0] paddr_i;
    wire  [31:0] pwdata_i, prdata_o;
    wire  [3:0]  pstrb_i, rate_code_o;
    wire         rate_valid_o, filt_cont_o, bw_reserved_o;
    wire  [1:0]  osr_mode_o;
    wire  [2:0]  avg_log2_o;
    wire  [5:0]  axis_map_o;
    integer      err_count = 0, total_checks = 0, seed = 57, cyc = 0, i;
    logic [8:0]  exp_q[$], e;
    logic [7:0]  data_q[$];
    logic [11:0] x;
    logic [11:0] ra [7] = '{12'h074, 12'h088, 12'h090, 12'h094, 12'h098, 12'h0a8, 12'h100};

    ascr_regs dut (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .acc_drdy_i, .aux_drdy_i, .temperature_i,
        .init_state_i, .sample_valid_i, .sample_data_i, .sample_ready_o, .rate_code_o,
        .rate_valid_o, .filt_cont_o, .osr_mode_o, .avg_log2_o, .bw_reserved_o, .axis_map_o);
    ascr_host host (.clk_i, .pready_i(pready_o), .psel_o(psel_i), .penable_o(penable_i),
        .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i), .pstrb_o(pstrb_i));

    initial forever #20 clk_i = ~clk_i;

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // expectation holds the error flag above the read byte
    task automatic op(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [8:0] ex);
        exp_q.push_back(ex);
        host.xfer(w, a, {24'h0, d}, s);
    endtask
    task automatic rd(input logic [11:0] a, input logic [8:0] ex);
        op(1'b0, a, 8'h00, 4'hf, ex);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        op(1'b1, a, d, 4'hf, 9'h000);
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (psel_i && penable_i && pready_o) begin
            e = exp_q.pop_front();
            if (pwrite_i) `CHK(pslverr_o, e[8])
            else `CHK({pslverr_o, prdata_o}, {e[8], 24'h0, e[7:0]})
        end
        if (cyc > 5000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (i = 0; i < 7; i++) rd(ra[i], {1'b0, i == 6 ? 8'ha8 : 8'h00});
        rd(12'h118, 9'h002);
        rd(12'h128, 9'h024);
        `CHK(axis_map_o, 6'h24)
        rd(12'h0fc, 9'h100);
        op(1'b1, 12'h101, 8'h55, 4'hf, 9'h100);
        op(1'b1, 12'h100, 8'h00, 4'h0, 9'h000);
        rd(12'h100, 9'h0a8);
        @(posedge clk_i);
        acc_drdy_i <= 1'b1;
        aux_drdy_i <= 1'b1;
        @(posedge clk_i);
        acc_drdy_i <= 1'b0;
        aux_drdy_i <= 1'b0;
        wr(12'h074, 8'h00);
        rd(12'h074, 9'h0a0);
        rd(12'h074, 9'h000);
        temperature_i <= $random(seed);
        wr(12'h088, 8'h5a);
        rd(12'h088, {1'b0, temperature_i});
        for (i = 0; i < 5; i++) begin
            init_state_i <= 5'(i);
            rd(12'h0a8, 9'(i));
        end
        wr(12'h128, 8'h64);
        wr(12'h100, 8'h46);
        rd(12'h0a8, 9'h044);
        wr(12'h128, 8'h00);
        rd(12'h0a8, 9'h024);
        `CHK(axis_map_o, 6'h00)
        for (i = 0; i < 8; i++) begin
            b = $random(seed);
            wr(12'h100, b);
            rd(12'h100, {1'b0, b});
            x = {b[3:0], b[3:0] >= 4'h1 && b[3:0] <= 4'hc, b[7],
                 b[7] ? (b[6:4] > 3'h2 ? 2'h3 : b[5:4]) : 2'h0, b[7] ? 3'h0 : b[6:4],
                 b[7] && b[6:4] > 3'h2};
            `CHK({rate_code_o, rate_valid_o, filt_cont_o, osr_mode_o, avg_log2_o, bw_reserved_o}, x)
        end
        // fill until the buffer refuses, host not reading meanwhile
        sample_valid_i <= 1'b1;
        sample_data_i <= $random(seed);
        i = 0;
        while (i < 4) begin
            @(posedge clk_i);
            if (sample_ready_o) begin
                data_q.push_back(sample_data_i);
                i++;
                sample_data_i <= $random(seed);
            end
        end
        @(posedge clk_i);
        `CHK(sample_ready_o, 1'b0)
        sample_valid_i <= 1'b0;
        rd(12'h074, 9'h003);
        rd(12'h090, 9'h004);
        rd(12'h094, 9'h000);
        while (data_q.size() > 0) rd(12'h098, {1'b0, data_q.pop_front()});
        rd(12'h090, 9'h000);
        rd(12'h098, 9'h000);
        repeat (2) @(posedge clk_i);
        final_report();
    end
endmodule
